// File: dcs_pkg.sv
package dcs_pkg;
  localparam int          DCS_W            = 32;
  localparam logic [3:0]  DCS_CTRL_REG_NUM = 4'h0;
  localparam logic [31:0] DCS_RESET_VAL    = 32'h0000_0000;
  localparam int          STATUS_MSB       = 31;
  localparam int          STATUS_LSB       = 28;
  localparam int          DOUBLE_FAULT_BIT = 27;
  localparam int          HW_TRIGGER_BIT   = 26;
  localparam int          HALT_BIT         = 25;
  localparam int          BREAK_PIN_BIT    = 24;
  localparam int          REV_MSB          = 23;
  localparam int          REV_LSB          = 20;
  localparam int          EDGE_MODE_BIT    = 18;
  localparam int          CLK_GATE_BIT     = 17;
  localparam int          WR_INHIBIT_BIT   = 16;
  localparam logic [3:0]  STATUS_RESET     = 4'h0;
  localparam logic [3:0]  REVISION_LEVEL   = 4'h0;
  localparam logic [31:0] CFG_LOW_MASK     = 32'h0000_FFFF;
  localparam logic [31:0] CPU_WR_MASK      = 32'h0006_FFFF;
  localparam logic [31:0] PORT_WR_MASK     = 32'h0007_FFFF;
  localparam logic [1:0]  TRACE_DIV_HALF   = 2'h1;
endpackage : dcs_pkg

// File: dcs_debug_csr.sv
`timescale 1ns/1ps
// Function
// [R1] system reset clears the whole register
// [R2] port reads and writes; cpu writes only
// [R3] cpu register zero; port read/write commands
// [R4] breakpoint state in bits 31..28
// [R5] state shown on idle debug data output
// [R6] trigger definition write resets state field
// [R7] double fault flag, cleared on read
// [R8] hardware trigger flag, cleared on read
// [R9] halt instruction flag, cleared on read
// [R10] break pin flag, cleared on read
// [R11] revision level read-only, zero initial
// [R12] edge mode: falling edge raises debug interrupt
// [R13] interrupt pends until instruction sample point
// [R14] no nested debug interrupts
// [R15] clock gate holds trace clock static
// [R16] write inhibit blocks cpu debug writes
// [R17] writes leave read-only fields alone
// [R18] tool drives clean falling break edge
module dcs_debug_csr (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        port_rd_i,
  input  wire logic        port_wr_i,
  input  wire logic [3:0]  port_reg_num_i,
  input  wire logic [31:0] port_wdata_i,
  input  wire logic        cpu_wr_i,
  input  wire logic [3:0]  cpu_reg_num_i,
  input  wire logic [31:0] cpu_wdata_i,
  input  wire logic        trigger_def_wr_i,
  input  wire logic [3:0]  brk_state_i,
  input  wire logic        brk_state_upd_i,
  input  wire logic        double_fault_evt_i,
  input  wire logic        hw_trigger_evt_i,
  input  wire logic        halt_instr_evt_i,
  input  wire logic        breakpoint_request_pin_i,
  input  wire logic        sample_point_i,
  input  wire logic        dbg_int_done_i,
  input  wire logic        data_out_busy_i,
  input  wire logic [3:0]  data_out_cpu_i,
  output logic      [31:0] port_rdata_o,
  output logic             port_rvalid_o,
  output logic             break_entry_o,
  output logic             dbg_int_start_o,
  output logic             dbg_int_active_o,
  output logic             cpu_write_inhibit_o,
  output logic             trace_clock_output_o,
  output logic      [3:0]  debug_data_output_o
);
  typedef struct packed {
    logic [3:0]  status;
    logic        dfault;
    logic        trig;
    logic        halt;
    logic        brk;
    logic        edge_mode;
    logic        clk_gate;
    logic        inhibit;
    logic [15:0] cfg_low;
    logic        pin_d;
    logic        pend;
    logic        active;
    logic        start;
    logic        entry;
    logic [31:0] rdata;
    logic        rvalid;
    logic [1:0]  div;
    logic        tclk;
    logic [3:0]  dout;
  } dcs_state_t;

  dcs_state_t  st_r;
  dcs_state_t  st_nxt;
  logic [31:0] cur_w;
  logic        port_hit;
  logic        cpu_hit;
  logic        rd_hit;
  logic        fall;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [31:0] merged;

  always_comb
  begin
    cur_w = 32'h0000_0000;
    cur_w[dcs_pkg::STATUS_MSB:dcs_pkg::STATUS_LSB] = st_r.status; // [R4]
    cur_w[dcs_pkg::DOUBLE_FAULT_BIT] = st_r.dfault;
    cur_w[dcs_pkg::HW_TRIGGER_BIT] = st_r.trig;
    cur_w[dcs_pkg::HALT_BIT] = st_r.halt;
    cur_w[dcs_pkg::BREAK_PIN_BIT] = st_r.brk;
    cur_w[dcs_pkg::REV_MSB:dcs_pkg::REV_LSB] = dcs_pkg::REVISION_LEVEL; // [R11]
    cur_w[dcs_pkg::EDGE_MODE_BIT] = st_r.edge_mode;
    cur_w[dcs_pkg::CLK_GATE_BIT] = st_r.clk_gate;
    cur_w[dcs_pkg::WR_INHIBIT_BIT] = st_r.inhibit;
    cur_w[15:0] = st_r.cfg_low;
    port_hit = port_wr_i && (port_reg_num_i == dcs_pkg::DCS_CTRL_REG_NUM); // [R3]
    // [R16] cpu writes dropped while inhibit is set
    cpu_hit = cpu_wr_i && (cpu_reg_num_i == dcs_pkg::DCS_CTRL_REG_NUM) && !st_r.inhibit; // [R3]
    rd_hit = port_rd_i && (port_reg_num_i == dcs_pkg::DCS_CTRL_REG_NUM); // [R2]
    fall = st_r.pin_d && !breakpoint_request_pin_i; // [R12]
    // port wins if both write; cpu mask excludes the inhibit bit
    if (port_hit)
    begin
      wmask = dcs_pkg::PORT_WR_MASK; // [R17]
      wdata = port_wdata_i;
    end
    else if (cpu_hit)
    begin
      wmask = dcs_pkg::CPU_WR_MASK; // [R17]
      wdata = cpu_wdata_i;
    end
    else
    begin
      wmask = 32'h0000_0000;
      wdata = 32'h0000_0000;
    end
    merged = (cur_w & ~wmask) | (wdata & wmask);
    st_nxt = st_r;
    st_nxt.edge_mode = merged[dcs_pkg::EDGE_MODE_BIT];
    st_nxt.clk_gate = merged[dcs_pkg::CLK_GATE_BIT];
    st_nxt.inhibit = merged[dcs_pkg::WR_INHIBIT_BIT]; // [R16]
    st_nxt.cfg_low = merged[15:0];
    if (brk_state_upd_i)
    begin
      st_nxt.status = brk_state_i; // [R4]
    end
    if (trigger_def_wr_i)
    begin
      st_nxt.status = dcs_pkg::STATUS_RESET; // [R6]
    end
    // read clears flags, but an event in the same cycle wins
    if (rd_hit)
    begin
      st_nxt.dfault = 1'b0;
      st_nxt.trig = 1'b0;
      st_nxt.halt = 1'b0;
      st_nxt.brk = 1'b0;
    end
    if (double_fault_evt_i)
    begin
      st_nxt.dfault = 1'b1; // [R7]
    end
    if (hw_trigger_evt_i)
    begin
      st_nxt.trig = 1'b1; // [R8]
    end
    if (halt_instr_evt_i)
    begin
      st_nxt.halt = 1'b1; // [R9]
    end
    st_nxt.pin_d = breakpoint_request_pin_i;
    st_nxt.entry = 1'b0;
    st_nxt.start = 1'b0;
    if (!st_r.edge_mode && fall)
    begin
      st_nxt.brk = 1'b1; // [R10]
      st_nxt.entry = 1'b1;
    end
    // falls while an interrupt is serviced are dropped, not queued
    if (st_r.edge_mode && fall && !st_r.active)
    begin
      st_nxt.pend = 1'b1; // [R12] [R14]
    end
    if (dbg_int_done_i)
    begin
      st_nxt.active = 1'b0;
    end
    if (st_r.pend && sample_point_i)
    begin
      st_nxt.pend = 1'b0; // [R13]
      st_nxt.active = 1'b1;
      st_nxt.start = 1'b1;
    end
    st_nxt.rvalid = rd_hit; // [R2]
    st_nxt.rdata = rd_hit ? cur_w : 32'h0000_0000;
    st_nxt.div = st_r.div + 2'h1;
    if (st_r.clk_gate)
    begin
      st_nxt.tclk = 1'b0; // [R15]
      st_nxt.div = 2'h0;
    end
    else if (st_r.div == dcs_pkg::TRACE_DIV_HALF)
    begin
      st_nxt.tclk = !st_r.tclk;
      st_nxt.div = 2'h0;
    end
    st_nxt.dout = data_out_busy_i ? data_out_cpu_i : st_r.status; // [R5]
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      st_r <= '0; // [R1]
    else
      st_r <= st_nxt;
  end

  assign port_rdata_o         = st_r.rdata;
  assign port_rvalid_o        = st_r.rvalid;
  assign break_entry_o        = st_r.entry;
  assign dbg_int_start_o      = st_r.start;
  assign dbg_int_active_o     = st_r.active;
  assign cpu_write_inhibit_o  = st_r.inhibit;
  assign trace_clock_output_o = st_r.tclk;
  assign debug_data_output_o  = st_r.dout;
endmodule : dcs_debug_csr

// File: dcs_tool.sv
`timescale 1ns/1ps
module dcs_tool (
  input  wire logic clk_i,
  input  wire logic drop_i,
  output logic      pin_o
);
  // pin idles high; a request is one clean fall held for whole cycles
  always @(posedge clk_i) pin_o <= ~drop_i;
endmodule : dcs_tool

// File: dcs_debug_csr_properties.sv
`timescale 1ns/1ps
module dcs_debug_csr_properties (
  input wire logic        clk_i, sys_rst_i, port_rd_i, port_wr_i, cpu_wr_i, data_out_busy_i, dbg_int_done_i,
  input wire logic        breakpoint_request_pin_i, port_rvalid_o, break_entry_o, dbg_int_start_o,
  input wire logic        dbg_int_active_o, cpu_write_inhibit_o,
  input wire logic [3:0]  port_reg_num_i, data_out_cpu_i, debug_data_output_o,
  input wire logic [31:0] port_wdata_i, port_rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RST_CLEAR: assert property ($past(sys_rst_i) |-> port_rdata_o == 32'h0 && !port_rvalid_o)
    else $error("outputs not clear after reset");
  AST_RD_ANSWER: assert property (port_rd_i && port_reg_num_i == 4'h0 |=> port_rvalid_o)
    else $error("read not answered");
  AST_REV_ZERO: assert property (port_rvalid_o |-> port_rdata_o[23:19] == 5'h0)
    else $error("revision field not zero");
  AST_CPU_NO_INHIBIT: assert property (cpu_wr_i && !port_wr_i |=> $stable(cpu_write_inhibit_o))
    else $error("cpu changed write inhibit");
  AST_PORT_INHIBIT: assert property (port_wr_i && port_reg_num_i == 4'h0
    |=> cpu_write_inhibit_o == $past(port_wdata_i[16]))
    else $error("port write inhibit lost");
  AST_DATA_OUT: assert property (data_out_busy_i |=> debug_data_output_o == $past(data_out_cpu_i))
    else $error("debug data not cpu data");
  AST_BREAK_CAUSE: assert property (break_entry_o |-> !$past(breakpoint_request_pin_i))
    else $error("break entry without pin low");
  AST_START_ACTIVE: assert property ($rose(dbg_int_start_o) |-> ##[0:1] dbg_int_active_o)
    else $error("interrupt start without active");
  AST_NO_NEST: assert property (dbg_int_active_o && !dbg_int_done_i |=> !dbg_int_start_o)
    else $error("nested debug interrupt");
endmodule : dcs_debug_csr_properties
bind dcs_debug_csr dcs_debug_csr_properties chk_u (.*);

// File: dcs_debug_csr_bench.sv
`timescale 1ns/1ps
module dcs_debug_csr_bench;
  logic clk_i = 0, sys_rst_i = 1, port_rd_i = 0, port_wr_i = 0, cpu_wr_i = 0, trigger_def_wr_i = 0;
  logic brk_state_upd_i = 0, double_fault_evt_i = 0, hw_trigger_evt_i = 0, halt_instr_evt_i = 0;
  logic sample_point_i = 0, dbg_int_done_i = 0, data_out_busy_i = 0, drop = 0, breakpoint_request_pin_i;
  logic port_rvalid_o, break_entry_o, dbg_int_start_o, dbg_int_active_o, cpu_write_inhibit_o, trace_clock_output_o;
  logic [3:0]  port_reg_num_i = 0, cpu_reg_num_i = 0, brk_state_i = 0, data_out_cpu_i = 0, debug_data_output_o;
  logic [31:0] port_wdata_i = 0, cpu_wdata_i = 0, port_rdata_o, e = 0, d;
  logic [3:0]  codes [5] = '{4'h0, 4'h2, 4'h4, 4'hA, 4'hC};
  int          failures = 0, checked = 0, seed = 8588, cyc = 0, i, n;
  dcs_debug_csr dut_u (.*);
  dcs_tool tool_u (.clk_i(clk_i), .drop_i(drop), .pin_o(breakpoint_request_pin_i));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc == 2000) begin failures++; give_verdict(); end
  function automatic logic [31:0] mix(input logic [31:0] o, v, m); return (o & ~m) | (v & m); endfunction : mix
  task tick(input int k); repeat (k) @(negedge clk_i); endtask : tick
  task chk(input logic [31:0] g, x);
    checked++;
    if (g !== x) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, x); end
  endtask : chk
  task rd(input logic [31:0] x);
    port_rd_i = 1; tick(1); port_rd_i = 0;
    chk({31'h0, port_rvalid_o}, 32'h1); chk(port_rdata_o, x);
    e[27:24] = 4'h0; tick(1);
  endtask : rd
  task wr(input logic c, input logic [3:0] r, input logic [31:0] v);
    if (c) {cpu_wr_i, cpu_reg_num_i, cpu_wdata_i} = {1'b1, r, v};
    else {port_wr_i, port_reg_num_i, port_wdata_i} = {1'b1, r, v};
    // inhibit blocks cpu only; neither path reaches status, flags or revision
    if (r == 4'h0) e = c ? (e[16] ? e : mix(e, v, dcs_pkg::CPU_WR_MASK)) : mix(e, v, dcs_pkg::PORT_WR_MASK);
    tick(1); cpu_wr_i = 0; port_wr_i = 0; port_reg_num_i = 0; tick(1);
  endtask : wr
  task tog(input int x);
    logic p;
    n = 0;
    repeat (8) begin p = trace_clock_output_o; tick(1); n += (p !== trace_clock_output_o); end
    chk(n, x);
  endtask : tog
  task give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    tick(8); sys_rst_i = 0; tick(1);
    rd(32'h0);
    {double_fault_evt_i, hw_trigger_evt_i, halt_instr_evt_i, drop} = 4'hF; tick(1);
    {double_fault_evt_i, hw_trigger_evt_i, halt_instr_evt_i} = 3'h0; tick(1);
    chk({31'h0, break_entry_o}, 32'h1);
    tick(1); chk({31'h0, break_entry_o}, 32'h0);
    tick(1); drop = 0; tick(2);
    rd(32'h0F00_0000);
    rd(32'h0);
    for (i = 0; i < 5; i++) begin
      d = $random(seed); brk_state_i = codes[i] | {3'h0, d[0]}; data_out_cpu_i = d[7:4];
      brk_state_upd_i = 1; tick(1);
      brk_state_upd_i = 0; e[31:28] = brk_state_i; tick(1);
      chk({28'h0, debug_data_output_o}, {28'h0, brk_state_i});
      rd(e);
      data_out_busy_i = 1; tick(2); chk({28'h0, debug_data_output_o}, {28'h0, data_out_cpu_i});
      data_out_busy_i = 0;
    end
    trigger_def_wr_i = 1; tick(1); trigger_def_wr_i = 0; e[31:28] = 4'h0; rd(e);
    for (i = 0; i < 12; i++) begin
      d = $random(seed); n = {$random(seed)} % 3;
      wr(n == 0, (n == 2) ? 4'h3 : 4'h0, d);
      rd(e);
      chk({31'h0, cpu_write_inhibit_o}, {31'h0, e[16]});
    end
    wr(0, 4'h0, 32'hFFFF_0000); wr(1, 4'h0, 32'h0000_1234); rd(e);
    chk({31'h0, cpu_write_inhibit_o}, 32'h1);
    wr(0, 4'h0, 32'h0004_0000); drop = 1; tick(3); drop = 0; sample_point_i = 1; tick(1); sample_point_i = 0;
    for (n = 0; n < 4 && dbg_int_start_o !== 1'b1; n++) tick(1);
    chk({31'h0, dbg_int_start_o}, 32'h1); tick(1); chk({31'h0, dbg_int_active_o}, 32'h1);
    drop = 1; tick(3); drop = 0; sample_point_i = 1; tick(3); sample_point_i = 0;
    chk({31'h0, dbg_int_start_o}, 32'h0);
    dbg_int_done_i = 1; tick(1); dbg_int_done_i = 0; tick(1); rd(e);
    wr(0, 4'h0, 32'h0002_0000); tog(0);
    wr(0, 4'h0, 32'h0); tog(4);
    give_verdict();
  end
endmodule : dcs_debug_csr_bench
